// ===== core/dsp_cfg.svh
// Constants of the DAC two-wire slave port: address, commands, resets.
// Assumes inclusion by bare name from the package or modules.
`ifndef DSP_CFG_SVH
`define DSP_CFG_SVH

// ----------------------------------------------------------------------
// Bus address and commands
// ----------------------------------------------------------------------
`define DSP_SLAVE_ADDR    7'h48
`define DSP_CMD_CODE      8'h00
`define DSP_CMD_CONFIG    8'h01

// ----------------------------------------------------------------------
// Field positions, reset values and code full scale
// ----------------------------------------------------------------------
`define DSP_STANDBY_BIT   0
`define DSP_CODE_RESET    12'h000
`define DSP_CONFIG_RESET  8'h00
`define DSP_CODE_FULL     4096

`endif

// ===== core/dsp_pkg.sv
// Types of the DAC two-wire slave port.
// Assumes the constants header sits beside it.
package dsp_pkg;
   typedef enum logic [2:0] {
      DSP_IDLE,
      DSP_RECV,
      DSP_RACK,
      DSP_SEND,
      DSP_SACK,
      DSP_IGNORE
   } dsp_state_t;

   typedef enum logic [1:0] {
      DSP_PH_ADDR,
      DSP_PH_CMD,
      DSP_PH_DATA
   } dsp_phase_t;
endpackage

// ===== core/dsp_sync.sv
// Two-flop synchroniser for pins from outside the clock domain.
// Assumes a free running clk_in; enable freezes the stages.
`timescale 1ns/1ns
module dsp_sync #(
   parameter int WIDTH = 2
) (
   input  wire logic             clk_in,
   input  wire logic             rst_n_in,
   input  wire logic             en_in,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_reg;

   // ------------------------------------------------------------------
   // Synchroniser stages, idle bus reads high
   // ------------------------------------------------------------------
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         meta_reg <= '1;
         sync_out <= '1;
      end else if (en_in) begin
         meta_reg <= async_in;
         sync_out <= meta_reg;
      end
   end
endmodule

// ===== core/dsp_slave.sv
// DAC two-wire slave port: register logic, standby and code output.
// Assumes scl and sda pins asynchronous; sda wire resolved outside.
//
// Notes on behaviour
// - Standby bit one means standby, zero normal
// - Standby freezes the converter code output
// - Serial port keeps working during standby
// - Answer only fixed address 1001000b
// - First byte after address is command
// - Read sends chosen register, MSB first
// - Shift on master SCL, drive only when due
// - Converter gets held code, out = ref*code/4096
// - Wrong address: no ack, ignore till start
// - Address bit eight: one read, zero write
// - Ack every byte received, except a wrong address byte
// - Code as two bytes, high then nibble
`timescale 1ns/1ns
`include "dsp_cfg.svh"
module dsp_slave
   import dsp_pkg::*;
(
   input  wire logic        clk_in,
   input  wire logic        rst_n_in,
   input  wire logic        clk_en_in,
   input  wire logic        scl_in,
   input  wire logic        sda_in,
   output logic             sda_out,
   output logic             sda_oe_n_out,
   output logic [11:0]      dac_code_out,
   output logic [11:0]      code_reg_out,
   output logic             standby_select_bit_out,
   output logic             busy_out
);
   typedef struct packed {
      dsp_state_t  state;
      dsp_phase_t  phase;
      logic        scl_d;
      logic        sda_d;
      logic [7:0]  shift;
      logic [3:0]  cnt;
      logic        rd;
      logic        second;
      logic [7:0]  cmd;
      logic [7:0]  hi_byte;
      logic [11:0] code;
      logic [7:0]  config_r;
      logic [11:0] dac;
      logic        sda_o;
      logic        oe_n;
      logic        busy;
   } dsp_st_t;

   dsp_st_t    st_reg;
   dsp_st_t    st_next;
   logic [1:0] pin_sync;
   logic       scl_s;
   logic       sda_s;
   logic       scl_rise;
   logic       scl_fall;
   logic       start_c;
   logic       stop_c;
   logic [7:0] tx_byte;

   // ------------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------------
   dsp_sync #(.WIDTH(2)) u_sync (
      .clk_in   (clk_in),
      .rst_n_in (rst_n_in),
      .en_in    (clk_en_in),
      .async_in ({scl_in, sda_in}),
      .sync_out (pin_sync)
   );

   // Bus events from synchronised pins
   assign scl_s    = pin_sync[1];
   assign sda_s    = pin_sync[0];
   assign scl_rise = scl_s & ~st_reg.scl_d;
   assign scl_fall = ~scl_s & st_reg.scl_d;
   assign start_c  = scl_s & st_reg.scl_d & st_reg.sda_d & ~sda_s;
   assign stop_c   = scl_s & st_reg.scl_d & ~st_reg.sda_d & sda_s;

   // Register byte to send, selected by command
   function automatic logic [7:0] rd_byte(input dsp_st_t s);
      if (s.cmd == `DSP_CMD_CONFIG)
         rd_byte = s.config_r;
      else if (!s.second)
         rd_byte = s.code[11:4];
      else
         rd_byte = {s.code[3:0], 4'h0};
   endfunction
   assign tx_byte = rd_byte(st_reg);

   // ------------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------------
   always_comb begin
      st_next       = st_reg;
      st_next.scl_d = scl_s;
      st_next.sda_d = sda_s;
      if (start_c) begin
         // Start or repeated start begins an address byte
         st_next.state = DSP_RECV;
         st_next.phase = DSP_PH_ADDR;
         st_next.cnt   = 4'h0;
         st_next.oe_n  = 1'b1;
         st_next.busy  = 1'b1;
      end else if (stop_c) begin
         st_next.state = DSP_IDLE;
         st_next.oe_n  = 1'b1;
         st_next.busy  = 1'b0;
      end else begin
         unique case (st_reg.state)
            DSP_IDLE, DSP_IGNORE: begin
               st_next.oe_n = 1'b1;
            end
            DSP_RECV: begin
               if (scl_rise) begin
                  st_next.shift = {st_reg.shift[6:0], sda_s};
                  st_next.cnt   = st_reg.cnt + 4'h1;
               end else if (scl_fall && st_reg.cnt == 4'h8) begin
                  st_next.cnt = 4'h0;
                  if (st_reg.phase == DSP_PH_ADDR &&
                      st_reg.shift[7:1] != `DSP_SLAVE_ADDR) begin
                     st_next.state = DSP_IGNORE;
                  end else begin
                     st_next.state = DSP_RACK;
                     st_next.sda_o = 1'b0;
                     st_next.oe_n  = 1'b0;
                  end
               end
            end
            DSP_RACK: begin
               if (scl_fall) begin
                  st_next.oe_n  = 1'b1;
                  st_next.state = DSP_RECV;
                  unique case (st_reg.phase)
                     DSP_PH_ADDR: begin
                        st_next.rd     = st_reg.shift[0];
                        st_next.second = 1'b0;
                        if (st_reg.shift[0]) begin
                           // Read data follows the acked address
                           st_next.state = DSP_SEND;
                           st_next.sda_o = tx_byte[7];
                           st_next.oe_n  = 1'b0;
                        end else begin
                           st_next.phase = DSP_PH_CMD;
                        end
                     end
                     DSP_PH_CMD: begin
                        st_next.cmd   = st_reg.shift;
                        st_next.phase = DSP_PH_DATA;
                     end
                     DSP_PH_DATA: begin
                        // Update once the final byte is acked
                        if (st_reg.cmd == `DSP_CMD_CONFIG) begin
                           st_next.config_r = {7'h00,
                              st_reg.shift[`DSP_STANDBY_BIT]};
                        end else if (!st_reg.second) begin
                           st_next.hi_byte = st_reg.shift;
                           st_next.second  = 1'b1;
                        end else begin
                           st_next.code   = {st_reg.hi_byte,
                                             st_reg.shift[7:4]};
                           st_next.second = 1'b0;
                        end
                     end
                     default: st_next.state = DSP_IGNORE;
                  endcase
               end
            end
            DSP_SEND: begin
               if (scl_fall) begin
                  if (st_reg.cnt == 4'h7) begin
                     st_next.cnt   = 4'h0;
                     st_next.oe_n  = 1'b1;           // master acks
                     st_next.state = DSP_SACK;
                  end else begin
                     st_next.cnt   = st_reg.cnt + 4'h1;
                     st_next.sda_o =
                        tx_byte[3'(4'h6 - st_reg.cnt)];
                  end
               end
            end
            DSP_SACK: begin
               if (scl_rise) begin
                  if (sda_s) begin
                     st_next.state = DSP_IGNORE;
                  end else begin
                     st_next.second = ~st_reg.second;
                  end
               end else if (scl_fall) begin
                  st_next.state = DSP_SEND;
                  st_next.sda_o = tx_byte[7];
                  st_next.oe_n  = 1'b0;
               end
            end
            default: st_next.state = DSP_IDLE;
         endcase
      end
      // Converter follows the code only in normal mode
      if (!st_reg.config_r[`DSP_STANDBY_BIT])
         st_next.dac = st_reg.code;
   end

   // ------------------------------------------------------------------
   // State register
   // ------------------------------------------------------------------
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         st_reg          <= '0;
         st_reg.state    <= DSP_IDLE;
         st_reg.phase    <= DSP_PH_ADDR;
         st_reg.scl_d    <= 1'b1;
         st_reg.sda_d    <= 1'b1;
         st_reg.sda_o    <= 1'b1;
         st_reg.oe_n     <= 1'b1;
         st_reg.code     <= `DSP_CODE_RESET;
         st_reg.config_r <= `DSP_CONFIG_RESET;
         st_reg.dac      <= `DSP_CODE_RESET;
      end else if (clk_en_in) begin
         st_reg <= st_next;
      end
   end

   // Outputs straight from the state register
   assign sda_out                = st_reg.sda_o;
   assign sda_oe_n_out           = st_reg.oe_n;
   assign dac_code_out           = st_reg.dac;
   assign code_reg_out           = st_reg.code;
   assign standby_select_bit_out = st_reg.config_r[`DSP_STANDBY_BIT];
   assign busy_out               = st_reg.busy;

   // ------------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------------
   sequence s_ack_due;
      st_reg.state == DSP_RECV && scl_fall && st_reg.cnt == 4'h8 &&
      !start_c && !stop_c && clk_en_in;
   endsequence

   property p_ack_low;
      @(posedge clk_in) disable iff (!rst_n_in)
      s_ack_due ##0 (st_reg.phase != DSP_PH_ADDR ||
         st_reg.shift[7:1] == `DSP_SLAVE_ADDR)
      |=> (!sda_oe_n_out && !sda_out);
   endproperty

   ack_drive_a: assert property (p_ack_low)
      else $error("ack not driven");

   addr_miss_a: assert property (@(posedge clk_in)
      disable iff (!rst_n_in) s_ack_due ##0 (st_reg.phase == DSP_PH_ADDR &&
         st_reg.shift[7:1] != `DSP_SLAVE_ADDR)
      |=> sda_oe_n_out && st_reg.state == DSP_IGNORE)
      else $error("wrong address answered");

   standby_hold_a: assert property (@(posedge clk_in)
      disable iff (!rst_n_in)
      standby_select_bit_out && $past(standby_select_bit_out) && clk_en_in
      |=> $stable(dac_code_out))
      else $error("converter moved in standby");

   normal_follow_a: assert property (@(posedge clk_in)
      disable iff (!rst_n_in)
      clk_en_in && !standby_select_bit_out
      |=> dac_code_out == $past(code_reg_out))
      else $error("converter not following code");

   nack_release_a: assert property (@(posedge clk_in)
      disable iff (!rst_n_in)
      st_reg.state == DSP_SACK && scl_rise && sda_s && clk_en_in
      |=> sda_oe_n_out [*2])
      else $error("sda held after nack");

   idle_release_a: assert property (@(posedge clk_in)
      disable iff (!rst_n_in)
      st_reg.state == DSP_IDLE || st_reg.state == DSP_IGNORE
      |-> ##1 (sda_oe_n_out || $past(start_c)))
      else $error("sda driven when idle");

   cfg_write_a: assert property (@(posedge clk_in)
      disable iff (!rst_n_in) st_reg.state == DSP_RACK &&
      st_reg.phase == DSP_PH_DATA && st_reg.cmd == `DSP_CMD_CONFIG &&
      scl_fall && !start_c && !stop_c && clk_en_in
      |=> standby_select_bit_out ==
          $past(st_reg.shift[`DSP_STANDBY_BIT]))
      else $error("config not written");

   cmd_latch_a: assert property (@(posedge clk_in)
      disable iff (!rst_n_in) st_reg.state == DSP_RACK &&
      st_reg.phase == DSP_PH_CMD && scl_fall && !start_c && !stop_c &&
      clk_en_in |=> st_reg.cmd == $past(st_reg.shift))
      else $error("command not taken");
endmodule

// ===== verif/dsp_host.sv
// Host bus master model for the two-wire port pins.
// Assumes a pull-up on the data wire, resolved by the bench.
`timescale 1ns/1ns
module dsp_host (
   input  wire logic sda_in,
   output logic      scl_out,
   output logic      sda_low_out
);
   // Quarter of the 800 ns bus clock period
   localparam int QTR = 200;

   // Idle bus: clock high and still, data released
   initial begin
      scl_out = 1'b1;
      sda_low_out = 1'b0;
   end

   // Start or repeated start; clock ends low
   task automatic start();
      #QTR sda_low_out = 1'b0;
      #QTR scl_out = 1'b1;
      #(2*QTR) sda_low_out = 1'b1;
      #(2*QTR) scl_out = 1'b0;
   endtask

   // Stop; clock then stands high
   task automatic stop();
      #QTR sda_low_out = 1'b1;
      #QTR scl_out = 1'b1;
      #(2*QTR) sda_low_out = 1'b0;
      #(2*QTR);
   endtask

   // One bit: data set mid-low, sampled at end of high
   task automatic xbit(input logic b, output logic r);
      #QTR sda_low_out = ~b;
      #QTR scl_out = 1'b1;
      #(2*QTR) r = sda_in;
      scl_out = 1'b0;
   endtask

   // Byte MSB first, then ninth bit at level a, sampled into s
   task automatic xfer(input logic [7:0] d, input logic a,
                       output logic [7:0] r, output logic s);
      for (int i = 7; i >= 0; i--) begin
         xbit(d[i], r[i]);
      end
      xbit(a, s);
   endtask
endmodule

// ===== verif/dsp_slave_tb.sv
// Testbench of the DAC two-wire slave port, driven by a host model.
// Assumes the design and host model are compiled before it.
`timescale 1ns/1ns
`include "dsp_cfg.svh"
module dsp_slave_tb;
   logic        clk_in, rst_n_in, sda_o, sda_oe_n, standby, busy, clk_en;
   logic [11:0] dac_code, code_reg;
   logic [7:0]  q;
   logic [3:0]  ak;
   wire         scl, sda_low, sda_wire;
   int          err_total = 0, num_checks = 0, cycles = 0;

   // Open-drain data wire with pull-up
   assign sda_wire = ~sda_low & (sda_oe_n | sda_o);

   dsp_host host_i (.sda_in(sda_wire), .scl_out(scl),
                    .sda_low_out(sda_low));
   dsp_slave dsp_slave_i (.clk_in(clk_in), .rst_n_in(rst_n_in),
      .clk_en_in(clk_en), .scl_in(scl), .sda_in(sda_wire),
      .sda_out(sda_o), .sda_oe_n_out(sda_oe_n),
      .dac_code_out(dac_code), .code_reg_out(code_reg),
      .standby_select_bit_out(standby), .busy_out(busy));

   // Counts, verdict and end of run
   task automatic wrap_up();
      $display("checks %0d errors %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // Compare a code, byte or ack vector
   task automatic chk_val(input logic [11:0] got, input logic [11:0] exp);
      num_checks++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch t=%0t got %h exp %h", $time, got, exp);
      end
   endtask

   // Compare a single flag
   task automatic chk_bit(input logic got, input logic exp);
      num_checks++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch t=%0t got %h exp %h", $time, got, exp);
      end
   endtask

   // Write: address, command, n data bytes from d; ack flags out
   task automatic wr(input logic [6:0] a, input logic [7:0] c, input int n,
                     input logic [15:0] d, output logic [3:0] k);
      logic [7:0] r;
      logic       s;
      k = 4'hf;
      host_i.start();
      host_i.xfer({a, 1'b0}, 1'b1, r, s);
      k[0] = ~s;
      if (a == `DSP_SLAVE_ADDR) begin
         chk_bit(busy, 1'b1);
      end else begin
         chk_bit(sda_oe_n, 1'b1);
      end
      host_i.xfer(c, 1'b1, r, s);
      k[1] = ~s;
      for (int i = 0; i < n; i++) begin
         host_i.xfer(d[15-8*i -: 8], 1'b1, r, s);
         k[2+i] = ~s;
      end
      host_i.stop();
      repeat (4) @(negedge clk_in);
      chk_bit(busy, 1'b0);
      chk_bit(sda_oe_n, 1'b1);
   endtask

   // Read one byte of register c; host ends with not-acknowledge
   task automatic rd(input logic [7:0] c, output logic [7:0] v,
                     output logic [3:0] k);
      logic [7:0] r;
      logic       s;
      k = 4'hf;
      host_i.start();
      host_i.xfer({`DSP_SLAVE_ADDR, 1'b0}, 1'b1, r, s);
      k[0] = ~s;
      host_i.xfer(c, 1'b1, r, s);
      k[1] = ~s;
      host_i.start();
      host_i.xfer({`DSP_SLAVE_ADDR, 1'b1}, 1'b1, r, s);
      k[2] = ~s;
      host_i.xfer(8'hff, 1'b1, v, s);
      host_i.stop();
      repeat (4) @(negedge clk_in);
      chk_bit(sda_oe_n, 1'b1);
   endtask

   // Outputs after reset
   task automatic t_reset();
      chk_val(code_reg, `DSP_CODE_RESET);
      chk_val(dac_code, `DSP_CODE_RESET);
      chk_bit(standby, 1'b0);
      chk_bit(sda_oe_n, 1'b1);
   endtask

   // Two-byte code write, unused low nibble set
   task automatic t_code();
      wr(`DSP_SLAVE_ADDR, `DSP_CMD_CODE, 2, 16'habc5, ak);
      chk_val(12'(ak), 12'h00f);
      chk_val(code_reg, 12'habc);
      chk_val(dac_code, 12'habc);
   endtask

   // Foreign addresses are neither acked nor obeyed
   task automatic t_bad_addr();
      wr(7'h49, `DSP_CMD_CODE, 2, 16'h5550, ak);
      chk_bit(ak[0], 1'b0);
      wr(7'h08, `DSP_CMD_CODE, 2, 16'h5550, ak);
      chk_bit(ak[0], 1'b0);
      chk_val(code_reg, 12'habc);
   endtask

   // Standby freezes output; port still writes and reads
   task automatic t_standby();
      wr(`DSP_SLAVE_ADDR, `DSP_CMD_CONFIG, 1, 16'hff00, ak);
      chk_bit(standby, 1'b1);
      wr(`DSP_SLAVE_ADDR, `DSP_CMD_CODE, 2, 16'h1230, ak);
      chk_val(12'(ak), 12'h00f);
      chk_val(code_reg, 12'h123);
      chk_val(dac_code, 12'habc);
      rd(`DSP_CMD_CONFIG, q, ak);
      chk_val(12'(q), 12'h001);
      wr(`DSP_SLAVE_ADDR, `DSP_CMD_CONFIG, 1, 16'h0000, ak);
      chk_bit(standby, 1'b0);
      chk_val(dac_code, 12'h123);
   endtask

   // Code read gives the high byte first
   task automatic t_read_code();
      rd(`DSP_CMD_CODE, q, ak);
      chk_val(12'(ak), 12'h00f);
      chk_val(12'(q), 12'h012);
   endtask

   // A lone code byte leaves the code unchanged
   task automatic t_short();
      wr(`DSP_SLAVE_ADDR, `DSP_CMD_CODE, 1, 16'hff00, ak);
      chk_val(code_reg, 12'h123);
   endtask

   // Enable low freezes the port: no ack, no busy, then recovers
   task automatic t_freeze();
      logic [7:0] r;
      logic       s;
      clk_en = 1'b0;
      host_i.start();
      host_i.xfer({`DSP_SLAVE_ADDR, 1'b0}, 1'b1, r, s);
      chk_bit(s, 1'b1);
      chk_bit(busy, 1'b0);
      host_i.stop();
      @(negedge clk_in);
      clk_en = 1'b1;
      repeat (4) @(negedge clk_in);
      chk_bit(busy, 1'b0);
      chk_val(code_reg, 12'h123);
      rd(`DSP_CMD_CODE, q, ak);
      chk_val(12'(q), 12'h012);
   endtask

   // Free running 10 MHz clock
   initial begin
      clk_in = 1'b0;
      forever #50 clk_in = ~clk_in;
   end

   // Hang guard on cycle count
   always @(posedge clk_in) begin
      cycles <= cycles + 1;
      if (cycles == 8000) begin
         err_total++;
         wrap_up();
      end
   end

   // Reset, then the scenarios
   initial begin
      clk_en   = 1'b1;
      rst_n_in = 1'b0;
      repeat (6) @(negedge clk_in);
      rst_n_in = 1'b1;
      repeat (4) @(negedge clk_in);
      t_reset();
      t_code();
      t_bad_addr();
      t_standby();
      t_read_code();
      t_short();
      t_freeze();
      wrap_up();
   end
endmodule
